//--- hdl/complementary_waveform_bridge.sv
// Four-channel bridge waveform generator with APB registers.
//
// Summary of operation
// R1: Forward bridge: A active, B/C idle, D modulated.
// R2: Reverse bridge: C active, A/D idle, B modulated.
// R3: Dead band inserted on every direction change; here only on a change while running, not on one made during shutdown.
// R4: Steering ignored in both full-bridge modes.
// R5: Direction bit may flip while enabled.
// R6: Keeps running in sleep on its own clock.
// R7: Fast oscillator kept alive when enabled, active, selected.
// R8: Sleep idles processor, generator keeps running.
// R9: Software clears enable before changing setup.
// R10: Enable starts from shutdown with programmed overrides.
// R11: Auto-restart clears shutdown, else software clears.
// R12: Software sets sources, dead times, clock first.
// R13: Pins stay inputs until module enabled.
// R14: Dead band counted in generator clock cycles.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
module complementary_waveform_bridge
    import cwb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] src_in,
    input  wire logic [31:0] src_active,
    input  wire logic [3:0]  shutdown_in,
    input  wire logic        sleep_req,
    output logic [3:0]       bridge_out,
    output logic             fast_osc_keep,
    output logic             cpu_idle
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        cfg_type         cfg;
        logic            shdn;
        logic            dir;
        gen_state_type   state;
        logic [3:0]      outs;
        logic            keep;
        logic            idle;
        logic [31:0]     rdata;
    } core_state_type;

    core_state_type s_reg;
    core_state_type s_next;

    logic            wr_take;
    logic            rd_setup;
    logic            sel_in;
    logic            sel_act;
    logic            sd_any;
    logic            flip;
    logic            db_load;
    logic [DB_W-1:0] db_value;
    logic            db_busy;
    logic [DB_W-1:0] db_count;

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic is_bridge(input logic [2:0] m);
        is_bridge = (m == MODE_FWD) || (m == MODE_REV);
    endfunction : is_bridge

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a <= OFS_STATUS) && (a[1:0] == 2'b00);
    endfunction : addr_hit

    // Override code 1x forces bit 0 onto the pin; 0x leaves it idle.
    function automatic logic ovr_pin(input logic [1:0] o,
                                     input logic inv);
        ovr_pin = o[1] ? o[0] : inv;
    endfunction : ovr_pin

    // ********************************************************
    // APB slave
    // ********************************************************
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit(paddr);
    assign wr_take  = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata   = s_reg.rdata;

    assign sel_in   = src_in[s_reg.cfg.isel];
    assign sel_act  = src_active[s_reg.cfg.isel];
    assign sd_any   = |(s_reg.cfg.src_en & shutdown_in);

    // Direction change seen while driving a full bridge.
    assign flip = (s_reg.state == ST_RUN)
                  && s_reg.cfg.en && !s_reg.shdn
                  && is_bridge(s_reg.cfg.mode)
                  && (s_reg.cfg.mode[0] != s_reg.dir);
    assign db_load  = flip; // see R3
    // Toward reverse uses the rising time, toward forward the falling.
    assign db_value = s_reg.cfg.mode[0] ? s_reg.cfg.dbr
                                        : s_reg.cfg.dbf;

    dead_band_timer u_dead_band (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (db_load),
        .load_value (db_value),
        .busy       (db_busy),
        .count      (db_count)
    ); // see R14

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        logic [3:0] raw;
        raw    = 4'h0;
        s_next = s_reg;

        // Setup is accepted at any time; keeping it stable while
        // enabled is left to software. see R9
        if (wr_take) begin
            case (paddr)
                OFS_MODE: begin
                    s_next.cfg.mode = pwdata[2:0]; // see R5
                    s_next.cfg.en   = pwdata[EN_BIT];
                end
                OFS_POLARITY: s_next.cfg.inv    = pwdata[3:0];
                OFS_INSEL:    s_next.cfg.isel   = pwdata[4:0];
                OFS_SDCTRL: begin
                    s_next.shdn    = pwdata[SHDN_BIT];
                    s_next.cfg.ren = pwdata[REN_BIT];
                end
                OFS_SDSRC:    s_next.cfg.src_en = pwdata[3:0];
                OFS_SDOVR: begin
                    s_next.cfg.ovr_ac = pwdata[1:0];
                    s_next.cfg.ovr_bd = pwdata[OVR_BD_LSB+1:OVR_BD_LSB];
                end
                OFS_DBRISE:   s_next.cfg.dbr    = pwdata[DB_W-1:0];
                OFS_DBFALL:   s_next.cfg.dbf    = pwdata[DB_W-1:0];
                OFS_CLKSEL:   s_next.cfg.clksel = pwdata[0];
                OFS_STEER:    s_next.cfg.steer  = pwdata[3:0];
                default: begin
                end
            endcase
        end

        // Auto-restart clears only once every enabled shutdown source is quiet.
        if (s_reg.cfg.ren && s_reg.shdn && !sd_any) begin
            s_next.shdn = 1'b0; // see R11
        end
        // Hardware set wins over any clear in the same cycle.
        if ((s_next.cfg.en && !s_reg.cfg.en)
            || (s_reg.cfg.en && sd_any)) begin
            s_next.shdn = 1'b1; // see R10
        end

        case (s_reg.state)
            ST_OFF: begin
                if (s_reg.cfg.en) begin
                    s_next.state = ST_SHUT; // see R10
                end
            end
            ST_SHUT: begin
                if (!s_reg.cfg.en) begin
                    s_next.state = ST_OFF;
                end else if (!s_reg.shdn) begin
                    s_next.state = ST_RUN;
                    s_next.dir   = s_reg.cfg.mode[0];
                end
            end
            ST_RUN: begin
                if (!s_reg.cfg.en) begin
                    s_next.state = ST_OFF;
                end else if (s_reg.shdn) begin
                    s_next.state = ST_SHUT;
                end else if (flip) begin
                    s_next.state = ST_DEAD; // see R3
                    s_next.dir   = s_reg.cfg.mode[0];
                end
            end
            ST_DEAD: begin
                if (!s_reg.cfg.en) begin
                    s_next.state = ST_OFF;
                end else if (s_reg.shdn) begin
                    s_next.state = ST_SHUT;
                end else if (!db_busy) begin
                    s_next.state = ST_RUN;
                end
            end
            default: s_next.state = ST_OFF;
        endcase

        // Logical drive: bit set means the channel is active.
        if (s_reg.state == ST_RUN && is_bridge(s_reg.cfg.mode)) begin
            if (!s_reg.dir) begin
                raw = {sel_in, 1'b0, 1'b0, 1'b1}; // see R1
            end else begin
                raw = {1'b0, 1'b1, sel_in, 1'b0}; // see R2
            end
        end else if (s_reg.state == ST_RUN) begin
            raw = s_reg.cfg.steer & {4{sel_in}}; // see R4
        end

        if (s_reg.state == ST_SHUT) begin
            s_next.outs[0] = ovr_pin(s_reg.cfg.ovr_ac, s_reg.cfg.inv[0]);
            s_next.outs[2] = ovr_pin(s_reg.cfg.ovr_ac, s_reg.cfg.inv[2]);
            s_next.outs[1] = ovr_pin(s_reg.cfg.ovr_bd, s_reg.cfg.inv[1]);
            s_next.outs[3] = ovr_pin(s_reg.cfg.ovr_bd, s_reg.cfg.inv[3]);
        end else begin
            // Off and dead band both rest at the idle level. see R13
            s_next.outs = raw ^ s_reg.cfg.inv;
        end

        // Sleep never gates the generator path itself. see R6
        s_next.keep = s_reg.cfg.en && sel_act
                      && s_reg.cfg.clksel; // see R7
        s_next.idle = sleep_req; // see R8

        if (rd_setup) begin
            case (paddr)
                OFS_MODE:     s_next.rdata = {24'h00_0000,
                                  s_reg.cfg.en, 4'h0, s_reg.cfg.mode};
                OFS_POLARITY: s_next.rdata = {28'h000_0000,
                                              s_reg.cfg.inv};
                OFS_INSEL:    s_next.rdata = {27'h000_0000,
                                              s_reg.cfg.isel};
                OFS_SDCTRL:   s_next.rdata = {24'h00_0000, s_reg.shdn,
                                              s_reg.cfg.ren, 6'h00};
                OFS_SDSRC:    s_next.rdata = {28'h000_0000,
                                              s_reg.cfg.src_en};
                OFS_SDOVR:    s_next.rdata = {28'h000_0000,
                                  s_reg.cfg.ovr_bd, s_reg.cfg.ovr_ac};
                OFS_DBRISE:   s_next.rdata = {26'h000_0000,
                                              s_reg.cfg.dbr};
                OFS_DBFALL:   s_next.rdata = {26'h000_0000,
                                              s_reg.cfg.dbf};
                OFS_CLKSEL:   s_next.rdata = {31'h0000_0000,
                                              s_reg.cfg.clksel};
                OFS_STEER:    s_next.rdata = {28'h000_0000,
                                              s_reg.cfg.steer};
                OFS_STATUS:   s_next.rdata = {23'h00_0000,
                                  s_reg.keep, s_reg.outs,
                                  s_reg.dir, s_reg.state, s_reg.shdn};
                default:      s_next.rdata = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg       <= '0;
            s_reg.cfg   <= CFG_RESET;
            s_reg.state <= ST_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bridge_out    = s_reg.outs;
    assign fast_osc_keep = s_reg.keep;
    assign cpu_idle      = s_reg.idle;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence run_fwd;
        s_reg.state == ST_RUN && is_bridge(s_reg.cfg.mode) && !s_reg.dir;
    endsequence

    sequence run_rev;
        s_reg.state == ST_RUN && is_bridge(s_reg.cfg.mode) && s_reg.dir;
    endsequence

    sequence dir_change;
        flip;
    endsequence

    a_forward_drive: assert property (run_fwd |=> // see R1
        bridge_out[2:0] == ($past(s_reg.cfg.inv[2:0]) ^ 3'b001)
        && bridge_out[3] == ($past(sel_in) ^ $past(s_reg.cfg.inv[3])))
        else $error("forward bridge outputs wrong");

    a_reverse_drive: assert property (run_rev |=> // see R2
        bridge_out[3] == $past(s_reg.cfg.inv[3])
        && bridge_out[2] == !$past(s_reg.cfg.inv[2])
        && bridge_out[0] == $past(s_reg.cfg.inv[0])
        && bridge_out[1] == ($past(sel_in) ^ $past(s_reg.cfg.inv[1])))
        else $error("reverse bridge outputs wrong");

    a_flip_dead: assert property (dir_change |=> // see R3
        s_reg.state == ST_DEAD && s_reg.dir == $past(s_reg.cfg.mode[0]))
        else $error("direction change skipped dead band");

    a_dead_quiet: assert property (s_reg.state == ST_DEAD |=> // see R3
        bridge_out == $past(s_reg.cfg.inv))
        else $error("outputs not idle in dead band");

    a_dead_length: assert property (dir_change |=> // see R14
        db_count == $past(db_value))
        else $error("dead band loaded with wrong count");

    a_enable_shut: assert property ( // see R10
        $rose(s_reg.cfg.en) |-> s_reg.shdn ##1 s_reg.state != ST_RUN)
        else $error("enable did not start in shutdown");

    a_auto_restart: assert property ( // see R11
        s_reg.shdn && s_reg.cfg.ren && s_reg.cfg.en && !sd_any
        |=> !s_reg.shdn)
        else $error("auto-restart did not clear shutdown");

    a_osc_keep: assert property ( // see R7
        s_reg.cfg.en && sel_act && s_reg.cfg.clksel |=> fast_osc_keep)
        else $error("fast oscillator not kept alive");

    a_sleep_idle: assert property ( // see R8
        sleep_req && s_reg.state == ST_RUN && s_reg.cfg.en
        && !s_reg.shdn && !flip |=> cpu_idle && s_reg.state == ST_RUN)
        else $error("sleep stopped the generator");

    a_shut_idle: assert property ( // see R10
        s_reg.state == ST_SHUT && s_reg.cfg.ovr_ac == 2'b00
        && s_reg.cfg.ovr_bd == 2'b00 |=> bridge_out == $past(s_reg.cfg.inv))
        else $error("shutdown override levels wrong");

    a_keep_drop: assert property ( // see R7
        !(s_reg.cfg.en && sel_act && s_reg.cfg.clksel) |=> !fast_osc_keep)
        else $error("fast oscillator kept without need");

    a_dead_exit: assert property ( // see R3
        s_reg.state == ST_DEAD && !db_busy && s_reg.cfg.en && !s_reg.shdn
        |=> s_reg.state == ST_RUN)
        else $error("dead band did not end");

endmodule : complementary_waveform_bridge

//--- hdl/cwb_pkg.sv
// Constants, types and register map of the complementary waveform bridge.
package cwb_pkg;

    // ********************************************************
    // Register offsets (byte addresses on APB)
    // ********************************************************
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_INSEL    = 8'h08;
    localparam logic [7:0] OFS_SDCTRL   = 8'h0C;
    localparam logic [7:0] OFS_SDSRC    = 8'h10;
    localparam logic [7:0] OFS_SDOVR    = 8'h14;
    localparam logic [7:0] OFS_DBRISE   = 8'h18;
    localparam logic [7:0] OFS_DBFALL   = 8'h1C;
    localparam logic [7:0] OFS_CLKSEL   = 8'h20;
    localparam logic [7:0] OFS_STEER    = 8'h24;
    localparam logic [7:0] OFS_STATUS   = 8'h28;

    // ********************************************************
    // Field positions and widths
    // ********************************************************
    localparam int EN_BIT     = 7;
    localparam int SHDN_BIT   = 7;
    localparam int REN_BIT    = 6;
    localparam int DB_W       = 6;
    localparam int OVR_BD_LSB = 2;

    // ********************************************************
    // Mode encodings and reset values
    // ********************************************************
    localparam logic [2:0] MODE_FWD   = 3'h2;
    localparam logic [2:0] MODE_REV   = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_SHUT = 2'b01,
        ST_RUN  = 2'b10,
        ST_DEAD = 2'b11
    } gen_state_type;

    // Software configuration carried as one group.
    typedef struct packed {
        logic [2:0]      mode;
        logic            en;
        logic [3:0]      inv;
        logic [4:0]      isel;
        logic [3:0]      steer;
        logic [1:0]      ovr_ac;
        logic [1:0]      ovr_bd;
        logic            ren;
        logic [3:0]      src_en;
        logic [DB_W-1:0] dbr;
        logic [DB_W-1:0] dbf;
        logic            clksel;
    } cfg_type;

    localparam cfg_type CFG_RESET = '{
        mode: MODE_RESET, en: 1'b0, inv: 4'h0, isel: 5'h00,
        steer: 4'h0, ovr_ac: 2'h0, ovr_bd: 2'h0, ren: 1'b0,
        src_en: 4'h0, dbr: 6'h00, dbf: 6'h00, clksel: 1'b0
    };

endpackage : cwb_pkg

//--- hdl/dead_band_timer.sv
// Down-counter that times one dead-band interval.
`timescale 1ns/1ns
module dead_band_timer
    import cwb_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            load,
    input  wire logic [DB_W-1:0] load_value,
    output logic                 busy,
    output logic [DB_W-1:0]      count
);

    typedef struct packed {
        logic [DB_W-1:0] cnt;
    } timer_state_type;

    timer_state_type t_reg;
    timer_state_type t_next;

    // One count per generator clock cycle.
    always_comb begin
        t_next = t_reg;
        if (load) begin
            t_next.cnt = load_value;
        end else if (t_reg.cnt != '0) begin
            t_next.cnt = t_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign busy  = (t_reg.cnt != '0);
    assign count = t_reg.cnt;

endmodule : dead_band_timer

//--- test/bridge_load_model.sv
// Behavioural model of the external power bridge on the four pins.
`timescale 1ns/1ns
module bridge_load_model (
    input  wire logic       pclk,
    input  wire logic [3:0] bridge_out,
    input  wire logic [3:0] pin_direction_bits,
    output logic [3:0]      gate_level,
    output logic [3:0]      edge_cnt
);
    logic [3:0] last_level = 4'h0;
    logic [3:0] cnt        = 4'h0;

    // A pin left as input floats; the bridge's pull-downs keep it off.
    always_comb begin
        gate_level = bridge_out & ~pin_direction_bits;
    end

    // Count gate transitions so a stuck drive shows up as no activity.
    always @(posedge pclk) begin
        if (gate_level !== last_level) begin
            cnt <= cnt + 4'h1;
        end
        last_level <= gate_level;
    end

    assign edge_cnt = cnt;
endmodule : bridge_load_model

//--- test/tb.sv
// Self-checking testbench for the complementary waveform bridge.
`timescale 1ns/1ns
module tb;
    import cwb_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sleep_req, fast_osc_keep, cpu_idle;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, src_in, src_active, rd;
    logic [3:0]  shutdown_in, bridge_out, pin_dir, gate_level, inv;
    logic [3:0]  edges, edges0;
    logic [4:0]  isel;
    logic [5:0]  dbr;
    logic [15:0] seed;
    logic        err;
    int          error_cnt, checks_done;

    complementary_waveform_bridge dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_in(src_in), .src_active(src_active),
        .shutdown_in(shutdown_in), .sleep_req(sleep_req),
        .bridge_out(bridge_out), .fast_osc_keep(fast_osc_keep),
        .cpu_idle(cpu_idle)
    );

    bridge_load_model load (
        .pclk(pclk), .bridge_out(bridge_out),
        .pin_direction_bits(pin_dir), .gate_level(gate_level),
        .edge_cnt(edges)
    );

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [3:0] exp_pins(input logic rev,
                                            input logic [3:0] iv,
                                            input logic s);
        logic [3:0] p;
        p = iv;
        if (rev) begin
            p[2] = ~iv[2];
            p[1] = s ^ iv[1];
        end else begin
            p[0] = ~iv[0];
            p[3] = s ^ iv[3];
        end
        return p;
    endfunction : exp_pins

    task automatic stop_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic cy(input int n);
        repeat (n) @(posedge pclk);
    endtask : cy

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Counts idle cycles on the pins after a direction flip.
    task automatic dead_len(input logic [31:0] mode_val, input int exp);
        int k, c;
        c = 0;
        apb(1'b1, OFS_MODE, mode_val);
        for (k = 0; k < 200; k++) begin
            @(negedge pclk);
            if (bridge_out === inv)
                c++;
            else if (c > 0)
                break;
        end
        chk(c, exp, "dead band length");
        @(posedge pclk);
    endtask : dead_len

    task automatic run_check(input logic rev);
        int k;
        for (k = 0; k < 6; k++) begin
            seed = lfsr_next(seed);
            src_in <= {seed, lfsr_next(seed)};
            cy(4);
            @(negedge pclk);
            chk(bridge_out, exp_pins(rev, inv, src_in[isel]), "pins");
            @(posedge pclk);
        end
    endtask : run_check

    // ********************************************************
    // Clock, reset and watchdog
    // ********************************************************
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        cy(20000);
        error_cnt++;
        stop_test;
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; src_in = 32'h0000_0000;
        src_active = 32'hFFFF_FFFF; shutdown_in = 4'h0; sleep_req = 1'b0;
        pin_dir = 4'hF; error_cnt = 0; checks_done = 0; seed = 16'd87;
        cy(4);
        presetn <= 1'b1;
        cy(1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, RD_ZERO, "status after reset");
        apb(1'b0, 8'h2C, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        seed = lfsr_next(seed);
        inv  = seed[3:0];
        isel = seed[8:4];
        dbr  = seed[15:10] | 6'h01;
        // Setup with the module disabled and pins still inputs.
        apb(1'b1, OFS_MODE, 32'h0000_0002);
        apb(1'b1, OFS_POLARITY, {28'h0, inv});
        apb(1'b1, OFS_INSEL, {27'h0, isel});
        apb(1'b1, OFS_STEER, {28'h0, ~seed[12:9]});
        apb(1'b1, OFS_SDOVR, 32'h0000_0000);
        apb(1'b1, OFS_DBRISE, {26'h0, dbr});
        apb(1'b1, OFS_DBFALL, 32'h0000_003F);
        apb(1'b1, OFS_CLKSEL, 32'h0000_0001);
        apb(1'b1, OFS_MODE, 32'h0000_0082);
        apb(1'b0, OFS_MODE, 32'h0);
        chk(rd, 32'h0000_0082, "mode readback");
        cy(3);
        chk(gate_level, 4'h0, "pins held off as inputs");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[2:0], 3'b011, "start in shutdown");
        chk(bridge_out, inv, "override levels");
        edges0 = edges;
        pin_dir <= 4'h0;
        apb(1'b1, OFS_SDCTRL, 32'h0000_0000);
        run_check(1'b0);
        chk(gate_level, bridge_out, "bridge sees pins");
        chk(edges != edges0, 1'b1, "bridge sees switching");
        src_in <= 32'h0000_0000;
        dead_len(32'h0000_0083, dbr + 1);
        run_check(1'b1);
        src_in <= 32'h0000_0000;
        dead_len(32'h0000_0082, 64);
        apb(1'b1, OFS_DBFALL, 32'h0000_0000);
        dead_len(32'h0000_0083, dbr + 1);
        dead_len(32'h0000_0082, 1);
        // Sleep with the fast oscillator as generator clock.
        sleep_req <= 1'b1;
        cy(3);
        chk({cpu_idle, fast_osc_keep}, 2'b11, "sleep keeps osc");
        run_check(1'b0);
        src_active[isel] <= 1'b0;
        cy(3);
        chk(fast_osc_keep, 1'b0, "inactive source");
        src_active[isel] <= 1'b1;
        apb(1'b1, OFS_CLKSEL, 32'h0000_0000);
        cy(3);
        chk(fast_osc_keep, 1'b0, "other clock");
        sleep_req <= 1'b0;
        // Shutdown with and without auto-restart.
        apb(1'b1, OFS_SDSRC, 32'h0000_0001);
        apb(1'b1, OFS_SDCTRL, 32'h0000_0040);
        shutdown_in <= 4'h1;
        cy(4);
        chk(bridge_out, inv, "shutdown overrides");
        shutdown_in <= 4'h0;
        cy(4);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[0], 1'b0, "auto restart");
        apb(1'b1, OFS_SDCTRL, 32'h0000_0000);
        shutdown_in <= 4'h1;
        cy(3);
        shutdown_in <= 4'h0;
        cy(4);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[0], 1'b1, "shutdown held");
        apb(1'b1, OFS_SDCTRL, 32'h0000_0000);
        run_check(1'b0);
        stop_test;
    end
endmodule : tb
